// >>> hdl/phrw_pkg.sv
/*
 package for the paged host register window: offsets, field positions,
 reset values and page geometry.
 assumes: a serial protocol engine presents byte accesses on a 7-bit offset.
*/
package phrw_pkg;
   localparam logic [6:0] PHRW_OFS_CTRL      = 7'h7E;
   localparam logic [6:0] PHRW_OFS_PAGE      = 7'h7F;
   localparam logic [6:0] PHRW_OFS_WIN_LAST  = 7'h7D;
   localparam int         PHRW_BIT_LOCKOUT   = 7;
   localparam int         PHRW_BIT_PENDING   = 0;
   localparam logic [7:0] PHRW_CTRL_RESET    = 8'h00;
   localparam logic [7:0] PHRW_PAGE_RESET    = 8'h00;
   localparam logic [7:0] PHRW_PAGE_LAST     = 8'h0F;
   localparam int         PHRW_OFS_W         = 7;
   localparam int         PHRW_FLAT_W        = 11;
endpackage

// >>> hdl/phrw_win_if.sv
/*
 interface carrying windowed accesses from the page decoder to the
 write gate.
 assumes: one clock, single-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
interface phrw_win_if;
   logic        wr;
   logic        rd;
   logic [10:0] flat_addr;
   logic [7:0]  wdata;
   logic        wr_fwd;
   logic        rd_fwd;
   modport dec  (output wr, output rd, output flat_addr, output wdata,
                 input wr_fwd, input rd_fwd);
   modport gate (input wr, input rd, input flat_addr, input wdata,
                 output wr_fwd, output rd_fwd);
endinterface
`default_nettype wire

// >>> hdl/phrw_wr_gate.sv
/*
 write gate for windowed accesses: drops page writes while lockout is set.
 assumes: lockout comes from the control register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module phrw_wr_gate (
   phrw_win_if.gate        win,
   input  wire logic       lockout_i
);
   assign win.wr_fwd = win.wr & ~lockout_i;
   assign win.rd_fwd = win.rd;
endmodule
`default_nettype wire

// >>> hdl/phrw_top.sv
/*
 paged host register window: page selector and host port control register,
 plus routing of windowed accesses to a flat register space.
 assumes: host protocol engine and page contents sit outside; strobes are
 one-cycle pulses on MCLK_I; core logic reports completed writes on WR_DONE_I.
*/
// Behaviour
// - control register is one register at offset 0x7E on every page
// - lockout bit 7 blocks page writes, not control or page selector
// - flash load never sets lockout; only host writes may
// - bit 0 shows 1 while any received write is unprocessed; code counts only forwarded page writes, saturating at 255
// - page selector is one 8-bit register at 0x7F on every page
// - offsets 0x00-0x7D go to the selected 128-byte page
// - values 0x00-0x0F select pages 0-15; higher values reserved
`timescale 1ns/1ps
`default_nettype none
module phrw_top (
   input  wire logic                         MCLK_I,
   input  wire logic                         RST_B_I,
   input  wire logic                         HOST_WR_I,
   input  wire logic                         HOST_RD_I,
   input  wire logic [phrw_pkg::PHRW_OFS_W-1:0] HOST_ADDR_I,
   input  wire logic [7:0]                   HOST_WDATA_I,
   output logic      [7:0]                   HOST_RDATA_O,
   input  wire logic                         FLASH_WR_I,
   input  wire logic [7:0]                   FLASH_CTRL_I,
   input  wire logic                         WR_DONE_I,
   output logic                              PAGE_WR_O,
   output logic                              PAGE_RD_O,
   output logic      [phrw_pkg::PHRW_FLAT_W-1:0] PAGE_ADDR_O,
   output logic      [7:0]                   PAGE_WDATA_O,
   input  wire logic [7:0]                   PAGE_RDATA_I,
   output logic                              PAGE_RESERVED_O,
   output logic                              LOCKOUT_O
);
   import phrw_pkg::*;

   logic       lockout_r;
   logic [7:0] page_r;
   logic [7:0] pend_cnt_r;
   logic       sel_ctrl;
   logic       sel_page;
   logic       sel_win;
   logic       pending;
   logic       win_accept;
   phrw_win_if win ();

   function automatic logic [PHRW_FLAT_W-1:0] flat_addr(input logic [7:0] pg,
                                                        input logic [6:0] ofs);
      flat_addr = {pg[3:0], ofs};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode: both fixed registers answer regardless of page
   assign sel_ctrl = (HOST_ADDR_I == PHRW_OFS_CTRL);
   assign sel_page = (HOST_ADDR_I == PHRW_OFS_PAGE);
   assign sel_win  = (HOST_ADDR_I <= PHRW_OFS_WIN_LAST);
   // reserved pages are not routed anywhere
   assign PAGE_RESERVED_O = (page_r > PHRW_PAGE_LAST);

   assign win.wr        = HOST_WR_I & sel_win & ~PAGE_RESERVED_O;
   assign win.rd        = HOST_RD_I & sel_win & ~PAGE_RESERVED_O;
   assign win.flat_addr = flat_addr(page_r, HOST_ADDR_I);
   assign win.wdata     = HOST_WDATA_I;

   phrw_wr_gate u_gate (
      .win       (win.gate),
      .lockout_i (lockout_r)
   );

   ////////////////////////////////////////////////////////////////////////
   // page access outputs, registered
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         PAGE_WR_O    <= 1'b0;
         PAGE_RD_O    <= 1'b0;
         PAGE_ADDR_O  <= '0;
         PAGE_WDATA_O <= 8'h00;
      end else begin
         PAGE_WR_O    <= win.wr_fwd;
         PAGE_RD_O    <= win.rd_fwd;
         PAGE_ADDR_O  <= win.flat_addr;
         PAGE_WDATA_O <= win.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // page selector: writable even under lockout
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         page_r <= PHRW_PAGE_RESET;
      end else if (HOST_WR_I && sel_page) begin
         page_r <= HOST_WDATA_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lockout: flash may clear it but never set it
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         lockout_r <= PHRW_CTRL_RESET[PHRW_BIT_LOCKOUT];
      end else if (HOST_WR_I && sel_ctrl) begin
         lockout_r <= HOST_WDATA_I[PHRW_BIT_LOCKOUT];
      end else if (FLASH_WR_I && !FLASH_CTRL_I[PHRW_BIT_LOCKOUT]) begin
         lockout_r <= 1'b0;
      end
   end
   assign LOCKOUT_O = lockout_r;

   ////////////////////////////////////////////////////////////////////////
   // pending count: accepted page writes minus completions
   // limitation: saturates at 255 outstanding writes
   assign win_accept = win.wr_fwd;
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         pend_cnt_r <= 8'h00;
      end else if (win_accept && !(WR_DONE_I && pend_cnt_r != 8'h00)) begin
         if (pend_cnt_r != 8'hFF) begin
            pend_cnt_r <= pend_cnt_r + 8'h01;
         end
      end else if (!win_accept && WR_DONE_I && pend_cnt_r != 8'h00) begin
         pend_cnt_r <= pend_cnt_r - 8'h01;
      end
   end
   assign pending = (pend_cnt_r != 8'h00);

   ////////////////////////////////////////////////////////////////////////
   // read data, registered; window reads pass page data one cycle later
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         HOST_RDATA_O <= 8'h00;
      end else if (HOST_RD_I && sel_ctrl) begin
         HOST_RDATA_O <= {lockout_r, 6'b00_0000, pending};
      end else if (HOST_RD_I && sel_page) begin
         HOST_RDATA_O <= page_r;
      end else if (PAGE_RD_O) begin
         HOST_RDATA_O <= PAGE_RDATA_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lockout: page writes blocked, the two fixed registers stay writable
   a_lock_blocks: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && sel_win && lockout_r) |=> !PAGE_WR_O)
      else $error("page write passed under lockout");
   a_lock_open: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && sel_win && !lockout_r && !PAGE_RESERVED_O) |=> PAGE_WR_O)
      else $error("page write dropped while unlocked");
   a_lock_ctrl: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && sel_ctrl) |=> (lockout_r == $past(HOST_WDATA_I[PHRW_BIT_LOCKOUT])))
      else $error("control register not writable");
   a_lock_page: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && sel_page && lockout_r) |=> (page_r == $past(HOST_WDATA_I)))
      else $error("page selector blocked by lockout");
   a_flash_nolock: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (!lockout_r && !(HOST_WR_I && sel_ctrl)) |=> !lockout_r)
      else $error("lockout set without host write");
   a_flash_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (FLASH_WR_I && !FLASH_CTRL_I[PHRW_BIT_LOCKOUT] && !(HOST_WR_I && sel_ctrl))
      |=> !lockout_r)
      else $error("flash load did not clear lockout");

   ////////////////////////////////////////////////////////////////////////
   // pending flag: follows the count of unprocessed writes
   a_pend_flag: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (win.wr_fwd && !WR_DONE_I) |=> pending)
      else $error("pending flag not set after write");
   a_pend_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (pend_cnt_r == 8'h01 && WR_DONE_I && !win.wr_fwd) |=> !pending)
      else $error("pending flag stuck after last completion");
   a_pend_hold: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (pending && !WR_DONE_I) |=> pending)
      else $error("pending flag dropped without completion");
   a_pend_idle: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (!pending && !win.wr_fwd) |=> !pending)
      else $error("pending flag rose without write");
   a_ctrl_pend: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_RD_I && sel_ctrl) |=> (HOST_RDATA_O[PHRW_BIT_PENDING] == $past(pending)))
      else $error("control read shows wrong pending bit");

   ////////////////////////////////////////////////////////////////////////
   // fixed registers answer on every page
   a_ctrl_read: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_RD_I && sel_ctrl) |=> (HOST_RDATA_O[7] == $past(lockout_r)))
      else $error("control read wrong");
   a_ctrl_rsvd: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_RD_I && sel_ctrl) |=> (HOST_RDATA_O[6:1] == 6'b00_0000))
      else $error("control read reserved bits not zero");
   a_page_store: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && sel_page) |=> (page_r == $past(HOST_WDATA_I)))
      else $error("page selector not written");
   a_page_keep: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      !(HOST_WR_I && sel_page) |=> (page_r == $past(page_r)))
      else $error("page selector changed without write");
   a_page_read: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_RD_I && sel_page) |=> (HOST_RDATA_O == $past(page_r)))
      else $error("page selector read wrong");

   ////////////////////////////////////////////////////////////////////////
   // window routing and flat address
   a_win_route: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && !sel_win) |=> !PAGE_WR_O)
      else $error("fixed register write leaked to page");
   a_win_read: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_RD_I && sel_win && !PAGE_RESERVED_O) |=> PAGE_RD_O)
      else $error("window read not forwarded");
   a_win_wdata: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      win.wr_fwd |=> (PAGE_WDATA_O == $past(HOST_WDATA_I)))
      else $error("page write data wrong");
   a_win_rdata: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (PAGE_RD_O && !(HOST_RD_I && (sel_ctrl || sel_page)))
      |=> (HOST_RDATA_O == $past(PAGE_RDATA_I)))
      else $error("page read data not returned");
   a_rsvd_page: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && page_r > PHRW_PAGE_LAST) |=> !PAGE_WR_O)
      else $error("write routed to reserved page");
   a_rsvd_read: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_RD_I && PAGE_RESERVED_O) |=> !PAGE_RD_O)
      else $error("read routed to reserved page");
   a_rsvd_flag: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      (HOST_WR_I && sel_page && HOST_WDATA_I > PHRW_PAGE_LAST) |=> PAGE_RESERVED_O)
      else $error("reserved page not flagged");
   a_flat_addr: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      win.wr_fwd |=> (PAGE_ADDR_O == {$past(page_r[3:0]), $past(HOST_ADDR_I)}))
      else $error("flat address wrong");
   a_flat_read: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      win.rd_fwd |=> (PAGE_ADDR_O == {$past(page_r[3:0]), $past(HOST_ADDR_I)}))
      else $error("flat read address wrong");
endmodule
`default_nettype wire

// >>> tb/phrw_page_model.sv
/*
 page space model: byte store behind the host window.
 assumes: read data is sampled only while the read strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none
module phrw_page_model (
   input  wire logic        clk,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [10:0] addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [0:2047];
   initial for (int k = 0; k < 2048; k++) mem[k] = 8'h00;
   always @(posedge clk) if (wr) mem[addr] <= wdata;
   // scrambled outside a read so stale data never passes
   assign rdata = rd ? mem[addr] : ~mem[addr];
endmodule
`default_nettype wire

// >>> tb/tb.sv
/*
 testbench for the paged host register window.
 assumes: page model on the far side; host strobes come from tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import phrw_pkg::*;
   logic        clk = 0, rst_b = 0, wr = 0, rd = 0, fwr = 0, done = 0;
   logic [6:0]  a = 0;
   logic [7:0]  wd = 0, fd = 0, rdat, prd, pwd, d, wv;
   logic [10:0] pa;
   logic        pwr, prs, res, lk;
   int          bad_count = 0, compares = 0;
   int unsigned seed, pg, ofs, i;
   always #5 clk = ~clk;
   phrw_top phrw_top_i (.MCLK_I(clk), .RST_B_I(rst_b), .HOST_WR_I(wr), .HOST_RD_I(rd),
      .HOST_ADDR_I(a), .HOST_WDATA_I(wd), .HOST_RDATA_O(rdat), .FLASH_WR_I(fwr),
      .FLASH_CTRL_I(fd), .WR_DONE_I(done), .PAGE_WR_O(pwr), .PAGE_RD_O(prs),
      .PAGE_ADDR_O(pa), .PAGE_WDATA_O(pwd), .PAGE_RDATA_I(prd),
      .PAGE_RESERVED_O(res), .LOCKOUT_O(lk));
   phrw_page_model phrw_page_model_i (.clk(clk), .wr(pwr), .rd(prs), .addr(pa),
      .wdata(pwd), .rdata(prd));
   function automatic logic [10:0] flat(input int unsigned p, input int unsigned o);
      return {p[3:0], o[6:0]};
   endfunction
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [6:0] ad, input logic [7:0] dv);
      a = ad;
      wd = dv;
      wr = 1;
      @(posedge clk) #1;
      wr = 0;
   endtask
   // window reads wait one more edge, so the page data has reached HOST_RDATA_O before it is sampled
   task automatic rreg(input logic [6:0] ad, input bit win, output logic [7:0] dv);
      a = ad;
      rd = 1;
      @(posedge clk) #1;
      rd = 0;
      if (win) chk(prs, 11'h001);
      if (win) @(posedge clk) #1;
      dv = rdat;
   endtask
   task automatic summarize;
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   initial begin
      seed = $urandom(32'h0000_cf0f);
      repeat (16) @(posedge clk);
      #1 rst_b = 1;
      @(posedge clk) #1;
      rreg(PHRW_OFS_CTRL, 0, d);
      chk(d, PHRW_CTRL_RESET);
      rreg(PHRW_OFS_PAGE, 0, d);
      chk(d, PHRW_PAGE_RESET);
      for (i = 0; i < 8; i++) begin
         pg = (i == 7) ? 15 : $urandom % 16;
         ofs = (i == 7) ? 125 : $urandom % 126;
         wv = $urandom;
         wreg(PHRW_OFS_PAGE, pg[7:0]);
         rreg(PHRW_OFS_PAGE, 0, d);
         chk(d, pg[10:0]);
         wreg(ofs[6:0], wv);
         chk(pwr, 11'h001);
         chk(pa, flat(pg, ofs));
         chk(pwd, wv);
         rreg(PHRW_OFS_CTRL, 0, d);
         chk(d, 11'h001);
         done = 1;
         @(posedge clk) #1;
         done = 0;
         rreg(PHRW_OFS_CTRL, 0, d);
         chk(d, 11'h000);
         rreg(ofs[6:0], 1, d);
         chk(d, wv);
      end
      fd = 8'h81;
      fwr = 1;
      @(posedge clk) #1;
      fwr = 0;
      rreg(PHRW_OFS_CTRL, 0, d);
      chk(d, 11'h000);
      wreg(PHRW_OFS_CTRL, 8'h80);
      chk(lk, 11'h001);
      wreg(7'h10, 8'h33);
      chk(pwr, 11'h000);
      rreg(PHRW_OFS_CTRL, 0, d);
      chk(d, 11'h080);
      wreg(PHRW_OFS_PAGE, 8'h03);
      rreg(PHRW_OFS_PAGE, 0, d);
      chk(d, 11'h003);
      fd = 8'h00;
      fwr = 1;
      @(posedge clk) #1;
      fwr = 0;
      chk(lk, 11'h000);
      wreg(PHRW_OFS_CTRL, 8'h00);
      chk(lk, 11'h000);
      wreg(PHRW_OFS_PAGE, 8'h10);
      chk(res, 11'h001);
      wreg(7'h10, 8'h44);
      chk(pwr, 11'h000);
      summarize();
   end
endmodule
`default_nettype wire
